// ===== rtl/osr_pkg.sv
// shared constants for the oversampling and decimation engine
package osr_pkg;
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int SAMPLE_W = 16;
    localparam int RESULT_W = 19;
    localparam int ACC_W = 22;
    localparam int CNT_W = 7;
    // rate_select_field encodings
    localparam logic [1:0] RATE_X1 = 2'h0;
    localparam logic [1:0] RATE_X4 = 2'h1;
    localparam logic [1:0] RATE_X16 = 2'h2;
    localparam logic [1:0] RATE_X64 = 2'h3;
    // sequencer modes
    localparam logic [1:0] MODE_STANDARD = 2'h0;
    localparam logic [1:0] MODE_ADVANCED = 2'h1;
    localparam logic [1:0] MODE_TWO_CYCLE = 2'h2;
    localparam logic [1:0] MODE_SINGLE_CYCLE = 2'h3;
    // register word offsets
    localparam logic [5:0] OFS_SETUP_BASE = 6'h00;
    localparam logic [5:0] OFS_CTRL = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h11;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h12;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h13;
    localparam logic [5:0] OFS_RESULT = 6'h14;
    localparam logic [5:0] OFS_UPPER = 6'h15;
    localparam logic [5:0] OFS_LOWER = 6'h16;
    localparam logic [5:0] OFS_LIMIT_FLAGS = 6'h17;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CTRL_BUSY_EN_BIT = 3;
    // irq bits
    localparam int IRQ_READY_BIT = 0;
    localparam int IRQ_LIMIT_BIT = 1;
    // reset values
    localparam logic [1:0] SETUP_RESET = 2'h0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] UPPER_RESET = 16'hffff;
    localparam logic [15:0] LOWER_RESET = 16'h0000;
    // autocycle timer period
    localparam int AUTO_PERIOD_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int AUTO_CYCLES = AUTO_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int AUTO_CNT_W = 10;
endpackage

// ===== rtl/osr_pulse_divider.sv
// autocycle timer: one-cycle conversion pulse every period
`timescale 1ns/1ps
module osr_pulse_divider
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic enable,
    input wire logic [osr_pkg::AUTO_CNT_W-1:0] period,
    // pulse
    output logic tick
);
    logic [osr_pkg::AUTO_CNT_W-1:0] cnt_reg;
    logic [osr_pkg::AUTO_CNT_W-1:0] cnt_next;
    logic tick_next;
    logic tick_reg;

    always_comb
    begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!enable)
        begin
            cnt_next = '0;
        end
        else if (cnt_reg >= period - 1'b1)
        begin
            cnt_next = '0;
            tick_next = 1'b1;
        end
        else
        begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ===== rtl/osr_sync2.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module osr_sync2
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level
    input wire logic d,
    output logic q
);
    logic s1_reg;
    logic s2_reg;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end

    assign q = s2_reg;
endmodule

// ===== rtl/osr_engine.sv
// oversampling and decimation engine with wishbone registers
`timescale 1ns/1ps
module osr_engine
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // conversion trigger pin
    input wire logic CONVERSION_TRIGGER,
    // converter core
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] SAMPLE_DATA,
    output logic CONVERT_START,
    // sequencer
    input wire logic CHANNEL_REQ,
    input wire logic [3:0] CHANNEL_SEL,
    output logic CHANNEL_DONE,
    output logic [3:0] MUX_CHANNEL,
    // result path
    output logic [18:0] RESULT_DATA,
    output logic [3:0] RESULT_CHANNEL,
    output logic RESULT_VALID,
    // flags
    output logic MULTI_FUNCTION_FLAG_PIN,
    output logic IRQ
);
    typedef enum {IDLE, WAIT_TRIG, WAIT_SAMPLE} state_t;

    // synchronised trigger and edge detect
    logic trig_sync;
    logic trig_prev_reg;
    logic auto_tick;
    logic trig_event;

    osr_sync2 trig_sync_i
    (
        .clk(CLOCK),
        .rst_b(RST_B),
        .d(CONVERSION_TRIGGER),
        .q(trig_sync)
    );

    // register state
    logic [1:0] rate_select_field_reg [osr_pkg::NUM_CH];
    logic [1:0] rate_select_field_next [osr_pkg::NUM_CH];
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_stat_next;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_mask_next;
    logic [15:0] upper_reg;
    logic [15:0] upper_next;
    logic [15:0] lower_reg;
    logic [15:0] lower_next;
    logic [15:0] upper_limit_flag_reg;
    logic [15:0] upper_limit_flag_next;
    logic [15:0] lower_limit_flag_reg;
    logic [15:0] lower_limit_flag_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;

    // datapath state
    state_t state_reg;
    state_t state_next;
    logic [3:0] chan_reg;
    logic [3:0] chan_next;
    logic [1:0] rate_reg;
    logic [1:0] rate_next;
    logic [osr_pkg::ACC_W-1:0] acc_reg;
    logic [osr_pkg::ACC_W-1:0] acc_next;
    logic [osr_pkg::CNT_W-1:0] cnt_reg;
    logic [osr_pkg::CNT_W-1:0] cnt_next;
    logic [18:0] result_reg;
    logic [18:0] result_next;
    logic [3:0] res_chan_reg;
    logic [3:0] res_chan_next;
    logic res_valid_reg;
    logic res_valid_next;
    logic busy_reg;
    logic busy_next;
    logic start_reg;
    logic start_next;

    logic [1:0] mode;
    logic auto_en;
    logic busy_en;
    logic [1:0] pick_rate;
    logic [osr_pkg::CNT_W-1:0] ratio_cnt;
    logic [osr_pkg::ACC_W-1:0] acc_sum;
    logic [18:0] avg_word;
    logic [15:0] cmp_word;
    logic [5:0] word_adr;
    logic wb_req;

    assign mode = ctrl_reg[osr_pkg::CTRL_MODE_LSB +: 2];
    assign auto_en = ctrl_reg[osr_pkg::CTRL_AUTO_BIT];
    assign busy_en = ctrl_reg[osr_pkg::CTRL_BUSY_EN_BIT];

    osr_pulse_divider auto_div_i
    (
        .clk(CLOCK),
        .rst_b(RST_B),
        .enable(auto_en),
        .period(osr_pkg::AUTO_CNT_W'(osr_pkg::AUTO_CYCLES)),
        .tick(auto_tick)
    );

    assign trig_event = auto_en ? auto_tick : (trig_sync & ~trig_prev_reg);

    always_comb
    begin
        unique case (mode)
            osr_pkg::MODE_STANDARD: pick_rate = rate_select_field_reg[0];
            osr_pkg::MODE_ADVANCED: pick_rate = rate_select_field_reg[CHANNEL_SEL];
            default: pick_rate = osr_pkg::RATE_X1;
        endcase
    end

    always_comb
    begin
        unique case (rate_reg)
            osr_pkg::RATE_X1: ratio_cnt = 7'd1;
            osr_pkg::RATE_X4: ratio_cnt = 7'd4;
            osr_pkg::RATE_X16: ratio_cnt = 7'd16;
            default: ratio_cnt = 7'd64;
        endcase
    end

    assign acc_sum = acc_reg + {6'h00, SAMPLE_DATA};

    always_comb
    begin
        // keep one extra bit per factor of four
        unique case (rate_reg)
            osr_pkg::RATE_X1: avg_word = {3'h0, acc_sum[15:0]};
            osr_pkg::RATE_X4: avg_word = {2'h0, acc_sum[17:1]};
            osr_pkg::RATE_X16: avg_word = {1'h0, acc_sum[19:2]};
            default: avg_word = acc_sum[21:3];
        endcase
    end

    // compare the 16 top bits of the averaged word
    always_comb
    begin
        unique case (rate_reg)
            osr_pkg::RATE_X1: cmp_word = avg_word[15:0];
            osr_pkg::RATE_X4: cmp_word = avg_word[16:1];
            osr_pkg::RATE_X16: cmp_word = avg_word[17:2];
            default: cmp_word = avg_word[18:3];
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        chan_next = chan_reg;
        rate_next = rate_reg;
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        res_chan_next = res_chan_reg;
        res_valid_next = 1'b0;
        busy_next = busy_reg;
        start_next = 1'b0;
        unique case (state_reg)
            IDLE:
            begin
                if (CHANNEL_REQ)
                begin
                    chan_next = CHANNEL_SEL;
                    rate_next = pick_rate;
                    acc_next = '0;
                    cnt_next = '0;
                    busy_next = 1'b1;
                    state_next = WAIT_TRIG;
                end
            end
            WAIT_TRIG:
            begin
                // each trigger event starts one conversion: a pin edge, or the autocycle tick when auto is set
                if (trig_event)
                begin
                    start_next = 1'b1;
                    state_next = WAIT_SAMPLE;
                end
            end
            WAIT_SAMPLE:
            begin
                if (SAMPLE_VALID)
                begin
                    acc_next = acc_sum;
                    cnt_next = cnt_reg + 1'b1;
                    // hold channel until ratio samples averaged
                    if (cnt_reg + 1'b1 == ratio_cnt)
                    begin
                        result_next = avg_word;
                        res_chan_next = chan_reg;
                        res_valid_next = 1'b1;
                        // busy drops only with the averaged word
                        busy_next = 1'b0;
                        state_next = IDLE;
                    end
                    else
                    begin
                        state_next = WAIT_TRIG;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_reg <= IDLE;
            chan_reg <= '0;
            rate_reg <= osr_pkg::RATE_X1;
            acc_reg <= '0;
            cnt_reg <= '0;
            result_reg <= '0;
            res_chan_reg <= '0;
            res_valid_reg <= 1'b0;
            busy_reg <= 1'b0;
            start_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            rate_reg <= rate_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            res_chan_reg <= res_chan_next;
            res_valid_reg <= res_valid_next;
            busy_reg <= busy_next;
            start_reg <= start_next;
            trig_prev_reg <= trig_sync;
        end
    end

    assign word_adr = WB_ADR_I[7:2];
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;

    always_comb
    begin
        rate_select_field_next = rate_select_field_reg;
        ctrl_next = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        irq_stat_next = irq_stat_reg;
        upper_limit_flag_next = upper_limit_flag_reg;
        lower_limit_flag_next = lower_limit_flag_reg;
        ack_next = wb_req;
        dat_next = '0;
        if (wb_req)
        begin
            if (word_adr < osr_pkg::OFS_CTRL)
            begin
                dat_next = {30'h0, rate_select_field_reg[word_adr[3:0]]};
                // host writes each channel's rate field
                if (WB_WE_I && WB_SEL_I[0])
                begin
                    rate_select_field_next[word_adr[3:0]] = WB_DAT_I[1:0];
                end
            end
            else
            begin
                unique case (word_adr)
                    osr_pkg::OFS_CTRL:
                    begin
                        dat_next = {28'h0, ctrl_reg[3:0]};
                        if (WB_WE_I && WB_SEL_I[0])
                        begin
                            ctrl_next = {28'h0, WB_DAT_I[3:0]};
                        end
                    end
                    osr_pkg::OFS_STATUS:
                        dat_next = {22'h0, cnt_reg, chan_reg[0], busy_reg, state_reg != IDLE};
                    osr_pkg::OFS_IRQ_STAT:
                    begin
                        dat_next = {30'h0, irq_stat_reg};
                        if (WB_WE_I && WB_SEL_I[0])
                        begin
                            irq_stat_next = irq_stat_reg & ~WB_DAT_I[1:0];
                        end
                    end
                    osr_pkg::OFS_IRQ_MASK:
                    begin
                        dat_next = {30'h0, irq_mask_reg};
                        if (WB_WE_I && WB_SEL_I[0])
                        begin
                            irq_mask_next = WB_DAT_I[1:0];
                        end
                    end
                    osr_pkg::OFS_RESULT:
                        dat_next = {9'h0, res_chan_reg, result_reg};
                    osr_pkg::OFS_UPPER:
                    begin
                        dat_next = {16'h0, upper_reg};
                        if (WB_WE_I && WB_SEL_I[1:0] == 2'h3)
                        begin
                            upper_next = WB_DAT_I[15:0];
                        end
                    end
                    osr_pkg::OFS_LOWER:
                    begin
                        dat_next = {16'h0, lower_reg};
                        if (WB_WE_I && WB_SEL_I[1:0] == 2'h3)
                        begin
                            lower_next = WB_DAT_I[15:0];
                        end
                    end
                    osr_pkg::OFS_LIMIT_FLAGS:
                    begin
                        dat_next = {upper_limit_flag_reg, lower_limit_flag_reg};
                        if (WB_WE_I)
                        begin
                            lower_limit_flag_next = lower_limit_flag_reg & ~WB_DAT_I[15:0];
                            upper_limit_flag_next = upper_limit_flag_reg & ~WB_DAT_I[31:16];
                        end
                    end
                    default:
                        dat_next = '0;
                endcase
            end
        end
        // events set after clears so a set wins
        if (res_valid_next)
        begin
            irq_stat_next[osr_pkg::IRQ_READY_BIT] = 1'b1;
            // limit flags only on the averaged result
            if (cmp_word >= upper_reg)
            begin
                upper_limit_flag_next[chan_reg] = 1'b1;
                irq_stat_next[osr_pkg::IRQ_LIMIT_BIT] = 1'b1;
            end
            if (cmp_word <= lower_reg)
            begin
                lower_limit_flag_next[chan_reg] = 1'b1;
                irq_stat_next[osr_pkg::IRQ_LIMIT_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < osr_pkg::NUM_CH; i++)
            begin
                rate_select_field_reg[i] <= osr_pkg::SETUP_RESET;
            end
            ctrl_reg <= osr_pkg::CTRL_RESET;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            upper_reg <= osr_pkg::UPPER_RESET;
            lower_reg <= osr_pkg::LOWER_RESET;
            upper_limit_flag_reg <= '0;
            lower_limit_flag_reg <= '0;
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end
        else
        begin
            rate_select_field_reg <= rate_select_field_next;
            ctrl_reg <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            upper_limit_flag_reg <= upper_limit_flag_next;
            lower_limit_flag_reg <= lower_limit_flag_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;
    assign CONVERT_START = start_reg;
    assign MUX_CHANNEL = chan_reg;
    assign CHANNEL_DONE = res_valid_reg;
    assign RESULT_DATA = result_reg;
    assign RESULT_CHANNEL = res_chan_reg;
    assign RESULT_VALID = res_valid_reg;
    // high while busy, low once data is ready
    assign MULTI_FUNCTION_FLAG_PIN = busy_en & busy_reg;
    assign IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule

// ===== tb/osr_core_model.sv
// converter core model: one sample per start pulse, after a set lag
`timescale 1ns/1ps
module osr_core_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic start,
    input wire logic [15:0] level,
    input wire logic [3:0] lag,
    // sample
    output logic valid,
    output logic [15:0] data
);
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            valid <= 1'b0;
            data <= 16'h0;
        end
        else
        begin
            valid <= 1'b0;
            if (valid)
                data <= ~data;
            if (start)
            begin
                busy <= 1'b1;
                cnt <= lag;
            end
            else if (busy && cnt == 4'h0)
            begin
                busy <= 1'b0;
                valid <= 1'b1;
                data <= level;
            end
            else if (busy)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

// ===== tb/osr_engine_chk.sv
// port assertions for the oversampling engine
`timescale 1ns/1ps
module osr_engine_chk
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    // conversion
    input wire logic SAMPLE_VALID,
    input wire logic CONVERT_START,
    input wire logic CHANNEL_DONE,
    input wire logic [3:0] MUX_CHANNEL,
    input wire logic [18:0] RESULT_DATA,
    input wire logic [3:0] RESULT_CHANNEL,
    input wire logic RESULT_VALID,
    input wire logic MULTI_FUNCTION_FLAG_PIN
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    sequence s_busy;
        MULTI_FUNCTION_FLAG_PIN ##1 MULTI_FUNCTION_FLAG_PIN;
    endsequence
    sequence s_pulse;
        CONVERT_START ##1 !CONVERT_START;
    endsequence
    sequence s_last;
        SAMPLE_VALID ##1 RESULT_VALID;
    endsequence
    ack_follows_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked next cycle");
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    dat_idle_zero_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero without ack");
    mux_hold_a: assert property (s_busy |-> $stable(MUX_CHANNEL))
        else $error("mux moved while busy");
    busy_fall_a: assert property ($fell(MULTI_FUNCTION_FLAG_PIN) |-> RESULT_VALID)
        else $error("flag fell without result");
    result_after_sample_a: assert property (RESULT_VALID |-> $past(SAMPLE_VALID))
        else $error("result not after a sample");
    done_with_result_a: assert property (RESULT_VALID == CHANNEL_DONE)
        else $error("done and result differ");
    result_chan_a: assert property (RESULT_VALID |-> RESULT_CHANNEL == MUX_CHANNEL)
        else $error("result channel differs from mux");
    result_stand_a: assert property (!RESULT_VALID |-> $stable(RESULT_DATA))
        else $error("result data changed without valid");
    start_pulse_a: assert property (CONVERT_START |-> s_pulse)
        else $error("start longer than one cycle");
    last_sample_c: cover property (s_last);
    busy_run_c: cover property (s_busy);
endmodule

bind osr_engine osr_engine_chk chk_u (.CLOCK(CLOCK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
    .SAMPLE_VALID(SAMPLE_VALID), .CONVERT_START(CONVERT_START), .CHANNEL_DONE(CHANNEL_DONE),
    .MUX_CHANNEL(MUX_CHANNEL), .RESULT_DATA(RESULT_DATA), .RESULT_CHANNEL(RESULT_CHANNEL),
    .RESULT_VALID(RESULT_VALID), .MULTI_FUNCTION_FLAG_PIN(MULTI_FUNCTION_FLAG_PIN));

// ===== tb/osr_engine_tb.sv
// self-checking bench for the oversampling engine
`timescale 1ns/1ps
module osr_engine_tb;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0, trig = 1'b0, req = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [18:0] gdat;
    logic [15:0] level = 16'h1234, sdat;
    logic [3:0] lag = 4'h0, sel = 4'h0, mux, rch, gch;
    logic ack, start, sv, rv, flag, irq;
    int n_mismatch = 0, cmp_count = 0, nsamp = 0, gcnt = 0, tick = 0;
    bit got = 0;
    osr_engine dut_u (.CLOCK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .CONVERSION_TRIGGER(trig), .SAMPLE_VALID(sv), .SAMPLE_DATA(sdat),
        .CONVERT_START(start), .CHANNEL_REQ(req), .CHANNEL_SEL(sel), .CHANNEL_DONE(),
        .MUX_CHANNEL(mux), .RESULT_DATA(gdat[18:0]), .RESULT_CHANNEL(rch),
        .RESULT_VALID(rv), .MULTI_FUNCTION_FLAG_PIN(flag), .IRQ(irq));
    osr_core_model core_u (.clk(clk), .rst_b(rst_b), .start(start), .level(level),
        .lag(lag), .valid(sv), .data(sdat));
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] ix, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= {ix, 2'h0};
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        rdat = dat_o;
        cyc <= 1'b0;
        if (n >= 50)
            chk(1, 0);
    endtask
    task automatic rd(input logic [5:0] ix, input logic [31:0] e);
        wb(1'b0, ix, 32'h0);
        chk(e, rdat);
    endtask
    task automatic trig_pulse();
        @(posedge clk);
        trig <= 1'b1;
        repeat (4) @(posedge clk);
        trig <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic run(input logic [3:0] ch, input int k, input bit ext);
        int r;
        int n;
        r = 1 << (2 * k);
        n = 0;
        wb(1'b1, 6'h17, 32'hffffffff);
        nsamp = 0;
        got = 0;
        @(posedge clk);
        req <= 1'b1;
        sel <= ch;
        @(posedge clk);
        req <= 1'b0;
        for (int i = 0; i < r && ext; i++)
        begin
            if (i == r / 2 && r > 1)
            begin
                chk(0, got);
                chk(1, flag);
                rd(6'h17, 32'h0);
            end
            trig_pulse();
        end
        while (!got && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        chk(r, gcnt);
        chk({16'h0, level} << k, {13'h0, gdat});
        chk(ch, gch);
        chk(ch, mux);
        if (!ext)
            chk(1, n > 3 * osr_pkg::AUTO_CYCLES && n < 5 * osr_pkg::AUTO_CYCLES);
    endtask
    always @(posedge clk)
    begin
        tick++;
        if (sv)
            nsamp++;
        if (rv)
        begin
            got = 1;
            gcnt = nsamp;
            gch = rch;
        end
        if (tick == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(6'h10, 32'h0);
        rd(6'h15, 32'h0000ffff);
        rd(6'h16, 32'h0);
        rd(6'h05, 32'h0);
        rd(6'h3f, 32'h0);
        wb(1'b1, 6'h10, 32'h8);
        wb(1'b1, 6'h00, 32'h2);
        run(4'h5, 2, 1'b1);
        chk(0, irq);
        rd(6'h12, 32'h1);
        wb(1'b1, 6'h13, 32'h1);
        repeat (2) @(posedge clk);
        chk(1, irq);
        wb(1'b1, 6'h12, 32'h1);
        repeat (2) @(posedge clk);
        chk(0, irq);
        wb(1'b1, 6'h10, 32'h9);
        lag = 4'h5;
        for (int c = 0; c < 4; c++)
        begin
            wb(1'b1, 6'h08 + 6'(c), 32'(c));
            run(4'h8 + 4'(c), c, 1'b1);
        end
        lag = 4'h0;
        level = 16'hffff;
        wb(1'b1, 6'h03, 32'h3);
        run(4'h3, 3, 1'b1);
        rd(6'h17, 32'h00080000);
        level = 16'h1234;
        // channel zero keeps ratio 16, so a fall back to it would show
        wb(1'b1, 6'h03, 32'h0);
        for (int m = 2; m < 4; m++)
        begin
            wb(1'b1, 6'h10, 32'h8 | 32'(m));
            run(4'h3, 0, 1'b1);
        end
        wb(1'b1, 6'h10, 32'hd);
        wb(1'b1, 6'h06, 32'h1);
        wb(1'b1, 6'h16, 32'h2000);
        run(4'h6, 1, 1'b0);
        rd(6'h17, 32'h00000040);
        rd(6'h14, 32'h00302468);
        report_and_stop();
    end
endmodule
